// *** inc/ubc_params.svh ***
// Constants for the baud control and status block
`ifndef UBC_PARAMS_SVH
`define UBC_PARAMS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define UBC_ADDR_BCS      8'h00
`define UBC_ADDR_IST      8'h04
`define UBC_ADDR_IMK      8'h08
`define UBC_ADDR_CFG      8'h0C
`define UBC_ADDR_DIV      8'h10

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define UBC_B_OVF         7
`define UBC_B_IDLE        6
`define UBC_B_POL         4
`define UBC_B_WIDE        3
`define UBC_B_WAKE        1
`define UBC_B_ABD         0
`define UBC_B_SYNC        0
`define UBC_I_WAKE        0
`define UBC_I_ABD         1
`define UBC_I_OVF         2
`define UBC_IRQ_W         3
`define UBC_BCS_RST       8'h40

// ****************************************************************
// Timing and bus answers
// ****************************************************************
`define UBC_FRAME_BITS    4'hA
`define UBC_ABD_LAST_RISE 3'h3
`define UBC_ABD_SHIFT     3
`define UBC_LIM_WIDE      16'hFFFF
`define UBC_LIM_NARROW    16'h00FF
`define UBC_RESP_OKAY     2'h0
`define UBC_RESP_SLVERR   2'h2

`endif

// *** inc/ubc_pkg.sv ***
// Types for the baud control and status block
package ubc_pkg;

   typedef enum logic [1:0] {
      ABD_IDLE  = 2'b00,
      ABD_START = 2'b01,
      ABD_FIRST = 2'b10,
      ABD_MEAS  = 2'b11
   } ubc_abd_e;

   typedef struct packed {
      logic        rx_m1;
      logic        rx_m2;
      logic        rx_m3;
      logic        rx_lvl;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        ovf;
      logic        rx_idle;
      logic        pol;
      logic        wide;
      logic        wake;
      logic        wake_seen;
      logic        abd_en;
      logic        sync_mode;
      logic [15:0] divisor;
      logic [15:0] brg_cnt;
      logic [15:0] abd_timer;
      logic [2:0]  abd_rises;
      ubc_abd_e    abd_st;
      logic [3:0]  bit_cnt;
      logic [2:0]  ist;
      logic [2:0]  imask;
      logic        irq;
      logic        tx;
      logic        ck;
   } ubc_state_s;

endpackage : ubc_pkg

// *** rtl/ubc_top.sv ***
// Baud control and status block with AXI4-Lite register access
//
// Function
// [RULE_01] Overflow flag set on auto-baud timer overflow
// [RULE_02] Receive-idle flag low during character reception
// [RULE_03] Polarity bit inverts transmit idle level, async
// [RULE_04] Polarity bit selects clock idle level, sync
// [RULE_05] Width bit set selects 16-bit generator
// [RULE_06] Width bit clear selects 8-bit generator
// [RULE_07] Wake: falling edge interrupts, rising edge clears
// [RULE_08] Wake clear: receive pin not monitored
// [RULE_09] Auto-baud measures 55h field, self-clears
// [RULE_10] Clear enable means disabled or completed
// [RULE_11] Bits 5 and 2 read zero, ignore writes
// [RULE_12] Reset: idle flag one, others zero
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ubc_params.svh"

module ubc_top #(
   parameter logic [3:0] FRAME_BITS = `UBC_FRAME_BITS
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // Write data channel
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // Write response channel
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // Read address channel
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   // Read data channel
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Serial lines and datapath
   input  wire logic        rx_pin,
   input  wire logic        tx_bit,
   input  wire logic        sync_clk_run,
   output logic             tx_pin,
   output logic             ck_pin,
   // Interrupt
   output logic             irq
);
   import ubc_pkg::*;

   ubc_state_s s_q;
   ubc_state_s s_d;
   logic       fall;
   logic       rise;
   logic       tick;
   logic [15:0] div_eff;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [2:0]  ev;
      logic        async_m;
      logic        rd_clr;
      logic [15:0] limit;
      logic [7:0]  bcs;
      logic [7:0]  a;
      ev      = '0;
      limit   = '0;
      rd_clr  = 1'b0;
      a       = '0;
      s_d     = s_q;
      async_m = ~s_q.sync_mode;
      bcs     = 8'h00;
      bcs[`UBC_B_OVF]  = s_q.ovf;
      bcs[`UBC_B_IDLE] = s_q.rx_idle;
      bcs[`UBC_B_POL]  = s_q.pol;
      bcs[`UBC_B_WIDE] = s_q.wide;
      bcs[`UBC_B_WAKE] = s_q.wake;
      bcs[`UBC_B_ABD]  = s_q.abd_en;

      // Three-stage pin sampler; a change counts once the last two stages agree
      s_d.rx_m1 = rx_pin;
      s_d.rx_m2 = s_q.rx_m1;
      s_d.rx_m3 = s_q.rx_m2;
      if (s_q.rx_m2 == s_q.rx_m3) begin
         s_d.rx_lvl = s_q.rx_m3;
      end
      fall = s_q.rx_lvl & ~s_d.rx_lvl;
      rise = ~s_q.rx_lvl & s_d.rx_lvl;

      // Baud generator: narrow mode ignores the divisor high byte
      div_eff = s_q.wide ? s_q.divisor                      // [RULE_05]
                         : {8'h00, s_q.divisor[7:0]};        // [RULE_06]
      limit   = s_q.wide ? `UBC_LIM_WIDE : `UBC_LIM_NARROW;
      tick    = (s_q.brg_cnt == 16'h0000);
      s_d.brg_cnt = tick ? div_eff : s_q.brg_cnt - 16'h0001;

      // ****************************************************************
      // Register bus
      // ****************************************************************
      if (awvalid && s_q.awready) begin
         s_d.awaddr  = awaddr;
         s_d.awready = 1'b0;
      end
      if (wvalid && s_q.wready) begin
         s_d.wdata  = wdata;
         s_d.wstrb  = wstrb;
         s_d.wready = 1'b0;
      end
      if (!s_q.awready && !s_q.wready && !s_q.bvalid) begin
         s_d.bvalid = 1'b1;
         s_d.bresp  = `UBC_RESP_OKAY;
         a = {s_q.awaddr[7:2], 2'b00};
         if (a == `UBC_ADDR_BCS) begin
            // Read-only and unimplemented positions are not stored
            if (s_q.wstrb[0]) begin                          // [RULE_11]
               s_d.pol    = s_q.wdata[`UBC_B_POL];
               s_d.wide   = s_q.wdata[`UBC_B_WIDE];
               s_d.wake   = s_q.wdata[`UBC_B_WAKE];
               s_d.abd_en = s_q.wdata[`UBC_B_ABD];
            end
         end else if (a == `UBC_ADDR_IMK) begin
            if (s_q.wstrb[0]) begin
               s_d.imask = s_q.wdata[`UBC_IRQ_W-1:0];
            end
         end else if (a == `UBC_ADDR_CFG) begin
            if (s_q.wstrb[0]) begin
               s_d.sync_mode = s_q.wdata[`UBC_B_SYNC];
            end
         end else if (a == `UBC_ADDR_DIV) begin
            if (s_q.wstrb[0]) begin
               s_d.divisor[7:0] = s_q.wdata[7:0];
            end
            if (s_q.wstrb[1]) begin
               s_d.divisor[15:8] = s_q.wdata[15:8];
            end
         end else if (a != `UBC_ADDR_IST) begin
            s_d.bresp = `UBC_RESP_SLVERR;
         end
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid  = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready  = 1'b1;
      end
      if (arvalid && s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = `UBC_RESP_OKAY;
         s_d.rdata   = 32'h0000_0000;
         a = {araddr[7:2], 2'b00};
         unique case (a)
            `UBC_ADDR_BCS: s_d.rdata[7:0] = bcs;             // [RULE_11]
            `UBC_ADDR_IST: begin
               s_d.rdata[`UBC_IRQ_W-1:0] = s_q.ist;
               rd_clr = 1'b1;
            end
            `UBC_ADDR_IMK: s_d.rdata[`UBC_IRQ_W-1:0] = s_q.imask;
            `UBC_ADDR_CFG: s_d.rdata[`UBC_B_SYNC] = s_q.sync_mode;
            `UBC_ADDR_DIV: s_d.rdata[15:0] = s_q.divisor;
            default:       s_d.rresp = `UBC_RESP_SLVERR;
         endcase
      end
      if (s_q.rvalid && rready) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end

      // ****************************************************************
      // Receive-idle tracking
      // ****************************************************************
      if (async_m) begin
         if (s_q.rx_idle && fall && !s_q.wake) begin
            s_d.rx_idle = 1'b0;                              // [RULE_02]
            s_d.bit_cnt = 4'h0;
            // Realign the generator so bit boundaries follow the start
            s_d.brg_cnt = div_eff;
         end else if (!s_q.rx_idle && tick) begin
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            if (s_q.bit_cnt == FRAME_BITS - 4'h1) begin
               s_d.rx_idle = 1'b1;                           // [RULE_02]
            end
         end
      end else begin
         s_d.rx_idle = 1'b1;
      end

      // ****************************************************************
      // Wake-up monitor
      // ****************************************************************
      if (async_m && s_q.wake) begin
         if (fall) begin
            ev[`UBC_I_WAKE] = 1'b1;                          // [RULE_07]
            s_d.wake_seen   = 1'b1;
         end
         if (rise && s_q.wake_seen) begin
            s_d.wake      = 1'b0;                            // [RULE_07]
            s_d.wake_seen = 1'b0;
         end
      end
      if (!s_q.wake) begin
         s_d.wake_seen = 1'b0;                               // [RULE_08]
      end

      // ****************************************************************
      // Auto-baud measurement over the 55h field
      // ****************************************************************
      // Timing runs from the first to the fifth rising edge, eight bits
      unique case (s_q.abd_st)
         ABD_IDLE: begin
            if (s_q.abd_en && async_m) begin
               s_d.abd_st = ABD_START;
               s_d.ovf    = 1'b0;                            // [RULE_01]
            end
         end
         ABD_START: begin
            if (fall) begin
               s_d.abd_st = ABD_FIRST;
            end
         end
         ABD_FIRST: begin
            if (rise) begin
               s_d.abd_st    = ABD_MEAS;                     // [RULE_09]
               s_d.abd_timer = 16'h0000;
               s_d.abd_rises = 3'h0;
            end
         end
         ABD_MEAS: begin
            s_d.abd_timer = s_q.abd_timer + 16'h0001;
            if (rise) begin
               s_d.abd_rises = s_q.abd_rises + 3'h1;
               if (s_q.abd_rises == `UBC_ABD_LAST_RISE) begin
                  s_d.divisor = s_q.abd_timer >> `UBC_ABD_SHIFT;
                  s_d.abd_en  = 1'b0;                        // [RULE_10]
                  s_d.abd_st  = ABD_IDLE;
                  ev[`UBC_I_ABD] = 1'b1;
               end
            end else if (s_q.abd_timer == limit) begin
               s_d.ovf    = 1'b1;                            // [RULE_01]
               s_d.abd_en = 1'b0;
               s_d.abd_st = ABD_IDLE;
               ev[`UBC_I_OVF] = 1'b1;
            end
         end
      endcase
      // Software abort or a switch to synchronous mode drops the run
      if (s_q.abd_st != ABD_IDLE && (!s_q.abd_en || !async_m)) begin
         s_d.abd_st = ABD_IDLE;
      end

      // ****************************************************************
      // Line drivers and interrupt
      // ****************************************************************
      if (async_m) begin
         s_d.tx = tx_bit ^ s_q.pol;                          // [RULE_03]
         s_d.ck = 1'b0;
      end else begin
         s_d.tx = tx_bit;
         if (!sync_clk_run) begin
            s_d.ck = s_q.pol;                                // [RULE_04]
         end else if (tick) begin
            s_d.ck = ~s_q.ck;
         end
      end
      // An event in the clearing cycle survives: set wins
      s_d.ist = (rd_clr ? 3'b000 : s_q.ist) | ev;
      s_d.irq = |(s_d.ist & s_d.imask);
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q         <= '0;                                  // [RULE_12]
         s_q.rx_m1   <= 1'b1;
         s_q.rx_m2   <= 1'b1;
         s_q.rx_m3   <= 1'b1;
         s_q.rx_lvl  <= 1'b1;
         s_q.rx_idle <= 1'(`UBC_BCS_RST >> `UBC_B_IDLE);     // [RULE_12]
         s_q.awready <= 1'b1;
         s_q.wready  <= 1'b1;
         s_q.arready <= 1'b1;
         s_q.tx      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign awready = s_q.awready;
   assign wready  = s_q.wready;
   assign bvalid  = s_q.bvalid;
   assign bresp   = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid  = s_q.rvalid;
   assign rresp   = s_q.rresp;
   assign rdata   = s_q.rdata;
   assign tx_pin  = s_q.tx;
   assign ck_pin  = s_q.ck;
   assign irq     = s_q.irq;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_ovf_set;
      s_q.abd_st == ABD_MEAS && !rise
      && s_q.abd_timer == (s_q.wide ? `UBC_LIM_WIDE : `UBC_LIM_NARROW)
      |=> s_q.ovf && !s_q.abd_en && s_q.ist[`UBC_I_OVF];
   endproperty
   a_ovf_set: assert property (p_ovf_set) // [RULE_01]
      else $error("overflow flag not set on timer overflow");

   property p_idle_busy;
      !s_q.sync_mode && s_q.rx_idle && fall && !s_q.wake
      |=> !s_q.rx_idle ##1 !s_q.rx_idle;
   endproperty
   a_idle_busy: assert property (p_idle_busy) // [RULE_02]
      else $error("receive idle flag did not drop on start bit");

   property p_tx_pol;
      !s_q.sync_mode |=> tx_pin == ($past(tx_bit) ^ $past(s_q.pol));
   endproperty
   a_tx_pol: assert property (p_tx_pol) // [RULE_03]
      else $error("transmit line polarity wrong");

   property p_ck_idle;
      s_q.sync_mode && !sync_clk_run |=> ck_pin == $past(s_q.pol);
   endproperty
   a_ck_idle: assert property (p_ck_idle) // [RULE_04]
      else $error("clock idle level wrong");

   property p_brg_wide;
      tick && s_q.wide |=> s_q.brg_cnt == $past(s_q.divisor);
   endproperty
   a_brg_wide: assert property (p_brg_wide) // [RULE_05]
      else $error("wide generator reload wrong");

   property p_brg_narrow;
      tick && !s_q.wide |=> s_q.brg_cnt[15:8] == 8'h00;
   endproperty
   a_brg_narrow: assert property (p_brg_narrow) // [RULE_06]
      else $error("narrow generator exceeds eight bits");

   sequence s_wake_fall;
      !s_q.sync_mode && s_q.wake && fall;
   endsequence
   sequence s_wake_rise;
      !s_q.sync_mode && s_q.wake && s_q.wake_seen && rise;
   endsequence

   property p_wake_irq;
      s_wake_fall |=> s_q.ist[`UBC_I_WAKE] && s_q.wake_seen;
   endproperty
   a_wake_irq: assert property (p_wake_irq) // [RULE_07]
      else $error("wake event not flagged");

   property p_wake_clear;
      s_wake_rise |=> !s_q.wake;
   endproperty
   a_wake_clear: assert property (p_wake_clear) // [RULE_07]
      else $error("wake bit not cleared on rising edge");

   property p_wake_off;
      !s_q.wake |=> !s_q.wake_seen;
   endproperty
   a_wake_off: assert property (p_wake_off) // [RULE_08]
      else $error("pin monitored with wake disabled");

   property p_abd_done;
      s_q.abd_st == ABD_MEAS && rise
      && s_q.abd_rises == `UBC_ABD_LAST_RISE
      |=> !s_q.abd_en && s_q.abd_st == ABD_IDLE
          && s_q.divisor == ($past(s_q.abd_timer) >> `UBC_ABD_SHIFT);
   endproperty
   a_abd_done: assert property (p_abd_done) // [RULE_09] [RULE_10]
      else $error("auto-baud completion wrong");

   property p_unimpl;
      arvalid && arready && {araddr[7:2], 2'b00} == `UBC_ADDR_BCS
      |=> rvalid && rdata[5] == 1'b0 && rdata[2] == 1'b0;
   endproperty
   a_unimpl: assert property (p_unimpl) // [RULE_11]
      else $error("unimplemented bits read nonzero");

   property p_reset_vals;
      $rose(aresetn) |-> s_q.rx_idle && !s_q.ovf && !s_q.pol
                         && !s_q.wide && !s_q.wake && !s_q.abd_en;
   endproperty
   a_reset_vals: assert property (p_reset_vals) // [RULE_12]
      else $error("reset values wrong");

endmodule : ubc_top
`default_nettype wire

// *** testbench/ubc_peer.sv ***
// Remote serial peer that drives the receive line of the block
`timescale 1ns/10ps
`default_nettype none

module ubc_peer (
   // Clock
   input  wire logic aclk,
   // Serial line towards the block
   output logic      rx_line
);
   initial rx_line = 1'b1;

   // Hold a level for n clocks; call just after a rising edge
   task automatic drive(input logic v, input int n);
      rx_line <= v;
      repeat (n) @(posedge aclk);
   endtask : drive

   // Odd bits run one clock longer, so eight bit times are not a
   // multiple of eight clocks and a truncating divide stays exact
   task automatic send_byte(input logic [7:0] b, input int per);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge aclk);
      for (int k = 0; k < 10; k++) begin
         drive(f[k], per + k % 2);
      end
   endtask : send_byte

   task automatic send_sync(input int per);
      send_byte(8'h55, per);
   endtask : send_sync
endmodule : ubc_peer
`default_nettype wire

// *** testbench/uart_baud_control_test.sv ***
// Self-checking bench for the baud control and status block
`timescale 1ns/10ps
`default_nettype none
`include "ubc_params.svh"
`define CHK(nm, e, g) begin compares++; \
   if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module uart_baud_control_test;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        tx_bit = 1'b1, sync_clk_run = 1'b0;
   wire logic   awready, wready, bvalid, arready, rvalid;
   wire logic   tx_pin, ck_pin, irq, rx_pin;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   int          compares = 0;
   int          n_mismatch = 0;
   logic [31:0] rdv;
   logic [1:0]  rsp;

   always #4 aclk = ~aclk;

   ubc_top #(.FRAME_BITS(4'hA)) i_ubc_top (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rx_pin(rx_pin), .tx_bit(tx_bit), .sync_clk_run(sync_clk_run),
      .tx_pin(tx_pin), .ck_pin(ck_pin), .irq(irq));

   ubc_peer i_ubc_peer (.aclk(aclk), .rx_line(rx_pin));

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // Register bus master
   // ****************************************************************
   task automatic bound(input int n);
      if (n >= 100) begin
         n_mismatch++;
         $display("MISMATCH bus_wait expected answer seen none");
         tally_and_finish();
      end
   endtask : bound

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd;
      int   n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (ad && wd && bvalid === 1'b1) break;
         if (!ad && awready === 1'b1) begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && wready === 1'b1) begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      rsp = bresp;
      bready <= 1'b0;
      bound(n);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic ad;
      int   n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      ad = 1'b0;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (ad && rvalid === 1'b1) break;
         if (!ad && arready === 1'b1) begin
            arvalid <= 1'b0;
            ad = 1'b1;
         end
      end
      rdv = rdata;
      rsp = rresp;
      rready <= 1'b0;
      bound(n);
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
      rd(a);
      `CHK(nm, e, rdv)
   endtask : rdchk

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      rdchk(`UBC_ADDR_BCS, 32'h40, "bcs_rst");
      `CHK("bcs_resp", 2'h0, rsp)
      rdchk(`UBC_ADDR_IST, 32'h0, "ist_rst");
      rdchk(`UBC_ADDR_IMK, 32'h0, "imk_rst");
      rdchk(`UBC_ADDR_CFG, 32'h0, "cfg_rst");
      `CHK("irq_rst", 1'b0, irq)
      // Writes to read-only and unused bits must leave them alone
      wr(`UBC_ADDR_BCS, 32'hFC);
      rdchk(`UBC_ADDR_BCS, 32'h58, "bcs_fixed");
      wr(8'h20, 32'hFF);
      `CHK("wr_unmapped", 2'h2, rsp)
      rd(8'h20);
      `CHK("rd_unmapped", 2'h2, rsp)
      `CHK("rd_unmapped_data", 32'h0, rdv)
      $display("test reset_and_fields done");
   endtask : t_reset

   task automatic t_txpol;
      logic [1:0] i;
      for (int k = 0; k < 4; k++) begin
         i = k[1:0];
         wr(`UBC_ADDR_BCS, {27'h0, i[1], 4'h0});
         tx_bit <= i[0];
         repeat (3) @(posedge aclk);
         `CHK("tx_pin", i[0] ^ i[1], tx_pin)
      end
      tx_bit <= 1'b1;
      $display("test tx_polarity done");
   endtask : t_txpol

   task automatic t_sync;
      logic v;
      int   n, k;
      wr(`UBC_ADDR_CFG, 32'h1);
      for (int p = 0; p < 2; p++) begin
         wr(`UBC_ADDR_BCS, p ? 32'h10 : 32'h00);
         repeat (3) @(posedge aclk);
         `CHK("ck_idle", p[0], ck_pin)
      end
      `CHK("tx_sync", 1'b1, tx_pin)
      wr(`UBC_ADDR_DIV, 32'h0103);
      sync_clk_run <= 1'b1;
      for (int w = 1; w >= 0; w--) begin
         wr(`UBC_ADDR_BCS, w ? 32'h08 : 32'h00);
         v = ck_pin;
         for (k = 0; k < 600 && ck_pin === v; k++) @(posedge aclk);
         v = ck_pin;
         for (n = 0; n < 600 && ck_pin === v; n++) @(posedge aclk);
         `CHK("tick", w ? 260 : 4, n)
      end
      sync_clk_run <= 1'b0;
      wr(`UBC_ADDR_CFG, 32'h0);
      $display("test sync_clock done");
   endtask : t_sync

   task automatic t_rxidle;
      wr(`UBC_ADDR_DIV, 32'h7);
      wr(`UBC_ADDR_BCS, 32'h08);
      fork
         i_ubc_peer.send_byte(8'hA5, 8);
         begin
            repeat (24) @(posedge aclk);
            rdchk(`UBC_ADDR_BCS, 32'h08, "idle_busy");
         end
      join
      repeat (60) @(posedge aclk);
      rdchk(`UBC_ADDR_BCS, 32'h48, "idle_back");
      $display("test receive_idle done");
   endtask : t_rxidle

   task automatic t_wake;
      wr(`UBC_ADDR_IMK, 32'h1);
      wr(`UBC_ADDR_BCS, 32'h02);
      i_ubc_peer.drive(1'b0, 10);
      rdchk(`UBC_ADDR_BCS, 32'h42, "wake_armed");
      `CHK("irq_wake", 1'b1, irq)
      i_ubc_peer.drive(1'b1, 10);
      rdchk(`UBC_ADDR_BCS, 32'h40, "wake_self_clr");
      rdchk(`UBC_ADDR_IST, 32'h1, "wake_event");
      i_ubc_peer.drive(1'b0, 10);
      i_ubc_peer.drive(1'b1, 150);
      rdchk(`UBC_ADDR_IST, 32'h0, "no_wake");
      $display("test wake done");
   endtask : t_wake

   task automatic t_autobaud;
      wr(`UBC_ADDR_IMK, 32'h7);
      wr(`UBC_ADDR_BCS, 32'h09);
      i_ubc_peer.send_sync(16);
      repeat (200) @(posedge aclk);
      `CHK("irq_abd", 1'b1, irq)
      rdchk(`UBC_ADDR_BCS, 32'h48, "abd_clr");
      rdchk(`UBC_ADDR_DIV, 32'h10, "abd_div");
      rdchk(`UBC_ADDR_IST, 32'h2, "abd_evt");
      repeat (3) @(posedge aclk);
      `CHK("irq_cleared", 1'b0, irq)
      rdchk(`UBC_ADDR_IST, 32'h0, "ist_clr");
      $display("test autobaud done");
   endtask : t_autobaud

   task automatic t_overflow;
      // Masked, so the event must not reach the interrupt line
      wr(`UBC_ADDR_IMK, 32'h0);
      wr(`UBC_ADDR_BCS, 32'h01);
      i_ubc_peer.send_sync(40);
      repeat (200) @(posedge aclk);
      `CHK("irq_masked", 1'b0, irq)
      rdchk(`UBC_ADDR_BCS, 32'hC0, "ovf_flag");
      rdchk(`UBC_ADDR_IST, 32'h4, "ovf_evt");
      $display("test overflow done");
   endtask : t_overflow

   initial begin
      #400000;
      n_mismatch++;
      $display("MISMATCH watchdog expected finish seen hang");
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_txpol();
      t_sync();
      t_rxidle();
      t_wake();
      t_autobaud();
      t_overflow();
      tally_and_finish();
   end
endmodule : uart_baud_control_test
`default_nettype wire
